// [inc/upper_port_pkg.sv]
/*
 * upper_port_pkg: register offsets, field widths and reset values for the
 * upper port group block (8-bit analog-shared port, 5-bit oscillator port,
 * 3-bit port with an output-only bit).
 * assumes: 32-bit AXI4-Lite register bus, one aligned word per register.
 */
package upper_port_pkg;
	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] group8_direction_off = 8'h00;
	localparam logic [7:0] group8_data_off = 8'h04;
	localparam logic [7:0] group12_direction_off = 8'h08;
	localparam logic [7:0] group12_data_off = 8'h0c;
	localparam logic [7:0] group12_pullup_off = 8'h10;
	localparam logic [7:0] group13_direction_off = 8'h14;
	localparam logic [7:0] group13_data_off = 8'h18;
	localparam logic [7:0] group13_pullup_off = 8'h1c;
	localparam logic [7:0] analog_pin_select_off = 8'h20;
	localparam logic [7:0] group8_pin_off = 8'h24;
	localparam logic [7:0] group12_pin_off = 8'h28;
	localparam logic [7:0] group13_pin_off = 8'h2c;

	// ****************************************
	// widths
	// ****************************************
	localparam int g8_w = 8;
	localparam int g12_w = 5;
	localparam int g13_w = 3;

	// ****************************************
	// reset values (direction 1 = input)
	// ****************************************
	localparam logic [7:0] group8_direction_rst = 8'hff;
	localparam logic [4:0] group12_direction_rst = 5'h1f;
	localparam logic [2:0] group13_direction_rst = 3'h6;
	localparam logic [7:0] group8_data_rst = 8'h00;
	localparam logic [4:0] group12_data_rst = 5'h00;
	localparam logic [2:0] group13_data_rst = 3'h0;
	localparam logic [4:0] group12_pullup_rst = 5'h00;
	localparam logic [2:0] group13_pullup_rst = 3'h0;
	// 1 = analog use of the shared pin
	localparam logic [7:0] analog_pin_select_rst = 8'h00;
	// writable masks
	localparam logic [4:0] group12_pullup_mask = 5'h01;
	localparam logic [2:0] group13_pullup_mask = 3'h6;
	localparam logic [2:0] group13_direction_mask = 3'h6;

	// ****************************************
	// AXI responses
	// ****************************************
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
endpackage : upper_port_pkg

// [rtl/pin_sync.sv]
/*
 * pin_sync: two flip-flop synchroniser for a vector of pad inputs.
 * assumes: pins are asynchronous to aclk; reset is synchronous active low.
 */
`timescale 1ns/100ps
module pin_sync
	import upper_port_pkg::*;
#(
	parameter int width = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [width-1:0] pin_async,
	output logic [width-1:0] pin_sync_q
);
	typedef struct packed {
		logic [width-1:0] meta;
		logic [width-1:0] stable;
	} sync_state_t;

	sync_state_t s_q;
	sync_state_t s_d;

	// first stage only feeds the second
	always_comb begin
		s_d = s_q;
		s_d.meta = pin_async;
		s_d.stable = s_q.meta;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pin_sync_q = s_q.stable;
endmodule : pin_sync

// [rtl/upper_port_io.sv]
/*
 * upper_port_io: general-purpose port logic for the upper port groups with
 * an AXI4-Lite register slave.
 * assumes: pad cells resolve out/oe/pullup to the wire; pins are async.
 */
// Overview of operation
// - eight-bit port, each bit individually set as input or output
// - five-bit port; only bit zero has a software pull-up
// - third group bit zero output-only, output state after reset
// - third group bits one and two are software-direction bidirectional
// - third group bits one and two have software pull-up enables
// - direction and data registers per port, pull-up registers for the five- and three-bit ports, plus analog pin select
// - reset places every bidirectional pin into input mode
`timescale 1ns/100ps
module upper_port_io
	import upper_port_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] analog_shared_pins_in,
	output logic [7:0] analog_shared_pins_out,
	output logic [7:0] analog_shared_pins_oe_n,
	output logic [7:0] analog_input_channels_en,
	input wire logic [4:0] osc_group_pins_in,
	output logic [4:0] osc_group_pins_out,
	output logic [4:0] osc_group_pins_oe_n,
	output logic [4:0] osc_group_pullup_en,
	input wire logic [2:0] third_group_pins_in,
	output logic [2:0] third_group_pins_out,
	output logic [2:0] third_group_pins_oe_n,
	output logic [2:0] third_group_pullup_en
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic awready;
		logic wready;
		logic arready;
		logic [7:0] group8_direction_reg;
		logic [7:0] group8_data_reg;
		logic [4:0] group12_direction_reg;
		logic [4:0] group12_data_reg;
		logic [4:0] group12_pullup_reg;
		logic [2:0] group13_direction_reg;
		logic [2:0] group13_data_reg;
		logic [2:0] group13_pullup_reg;
		logic [7:0] analog_pin_select_reg;
		logic [7:0] p8_out;
		logic [7:0] p8_oe_n;
		logic [7:0] p8_ana;
		logic [4:0] p12_out;
		logic [4:0] p12_oe_n;
		logic [4:0] p12_pu;
		logic [2:0] p13_out;
		logic [2:0] p13_oe_n;
		logic [2:0] p13_pu;
	} port_state_t;

	port_state_t s_q;
	port_state_t s_d;

	logic [7:0] p8_pin;
	logic [4:0] p12_pin;
	logic [2:0] p13_pin;
	logic [7:0] p8_rd;
	logic [4:0] p12_rd;
	logic [2:0] p13_rd;
	logic [7:0] wb;

	// ****************************************
	// pad input synchronisers
	// ****************************************
	pin_sync #(.width(g8_w)) u_sync8 (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_async(analog_shared_pins_in),
		.pin_sync_q(p8_pin)
	);
	pin_sync #(.width(g12_w)) u_sync12 (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_async(osc_group_pins_in),
		.pin_sync_q(p12_pin)
	);
	pin_sync #(.width(g13_w)) u_sync13 (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_async(third_group_pins_in),
		.pin_sync_q(p13_pin)
	);

	// ****************************************
	// data read-back: latch for outputs, pin for inputs, zero for analog-selected bits
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < g8_w; gi++) begin : g_rd8
			// analog-selected bits read zero: the digital input is cut off
			assign p8_rd[gi] = s_q.analog_pin_select_reg[gi] ? 1'b0 :
				(s_q.group8_direction_reg[gi] ? p8_pin[gi] : s_q.group8_data_reg[gi]);
		end
		for (gi = 0; gi < g12_w; gi++) begin : g_rd12
			assign p12_rd[gi] = s_q.group12_direction_reg[gi] ? p12_pin[gi] :
				s_q.group12_data_reg[gi];
		end
		for (gi = 0; gi < g13_w; gi++) begin : g_rd13
			assign p13_rd[gi] = s_q.group13_direction_reg[gi] ? p13_pin[gi] :
				s_q.group13_data_reg[gi];
		end
	endgenerate

	// low byte of the write, masked by its strobe
	function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
		input logic [31:0] data, input logic [3:0] strb);
		merge_byte = strb[0] ? data[7:0] : old_v;
	endfunction : merge_byte

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		wb = 8'h00;
		// address and data taken independently, in either order
		if (s_axi_awvalid && !s_q.aw_held && !s_q.bvalid) begin
			s_d.aw_held = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_held && !s_q.bvalid) begin
			s_d.w_held = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
			s_d.aw_held = 1'b0;
			s_d.w_held = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = resp_okay;
			case (s_q.aw_addr)
				group8_direction_off: begin
					wb = merge_byte(s_q.group8_direction_reg, s_q.w_data, s_q.w_strb);
					s_d.group8_direction_reg = wb;
				end
				group8_data_off: begin
					s_d.group8_data_reg = merge_byte(s_q.group8_data_reg, s_q.w_data,
						s_q.w_strb);
				end
				group12_direction_off: begin
					wb = merge_byte({3'h0, s_q.group12_direction_reg}, s_q.w_data,
						s_q.w_strb);
					s_d.group12_direction_reg = wb[4:0];
				end
				group12_data_off: begin
					wb = merge_byte({3'h0, s_q.group12_data_reg}, s_q.w_data, s_q.w_strb);
					s_d.group12_data_reg = wb[4:0];
				end
				group12_pullup_off: begin
					wb = merge_byte({3'h0, s_q.group12_pullup_reg}, s_q.w_data,
						s_q.w_strb);
					s_d.group12_pullup_reg = wb[4:0] & group12_pullup_mask;
				end
				group13_direction_off: begin
					wb = merge_byte({5'h00, s_q.group13_direction_reg}, s_q.w_data,
						s_q.w_strb);
					// bit zero stays output whatever is written
					s_d.group13_direction_reg = wb[2:0] & group13_direction_mask;
				end
				group13_data_off: begin
					wb = merge_byte({5'h00, s_q.group13_data_reg}, s_q.w_data, s_q.w_strb);
					s_d.group13_data_reg = wb[2:0];
				end
				group13_pullup_off: begin
					wb = merge_byte({5'h00, s_q.group13_pullup_reg}, s_q.w_data,
						s_q.w_strb);
					s_d.group13_pullup_reg = wb[2:0] & group13_pullup_mask;
				end
				analog_pin_select_off: begin
					s_d.analog_pin_select_reg = merge_byte(s_q.analog_pin_select_reg,
						s_q.w_data, s_q.w_strb);
				end
				group8_pin_off, group12_pin_off, group13_pin_off: begin
					// read-only pin views: write ignored
				end
				default: begin
					s_d.bresp = resp_slverr;
				end
			endcase
		end

		// reads: one in flight, answered the cycle after acceptance
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = resp_okay;
			case (s_axi_araddr)
				group8_direction_off: s_d.rdata = {24'h0, s_q.group8_direction_reg};
				group8_data_off: s_d.rdata = {24'h0, s_q.group8_data_reg};
				group12_direction_off: s_d.rdata = {27'h0, s_q.group12_direction_reg};
				group12_data_off: s_d.rdata = {27'h0, s_q.group12_data_reg};
				group12_pullup_off: s_d.rdata = {27'h0, s_q.group12_pullup_reg};
				group13_direction_off: s_d.rdata = {29'h0, s_q.group13_direction_reg};
				group13_data_off: s_d.rdata = {29'h0, s_q.group13_data_reg};
				group13_pullup_off: s_d.rdata = {29'h0, s_q.group13_pullup_reg};
				analog_pin_select_off: s_d.rdata = {24'h0, s_q.analog_pin_select_reg};
				group8_pin_off: s_d.rdata = {24'h0, p8_rd};
				group12_pin_off: s_d.rdata = {27'h0, p12_rd};
				group13_pin_off: s_d.rdata = {29'h0, p13_rd};
				default: begin
					s_d.rdata = 32'h0;
					s_d.rresp = resp_slverr;
				end
			endcase
		end

		// pad drive registered from the configuration
		// analog-selected pins are never driven digitally
		s_d.p8_oe_n = s_q.group8_direction_reg | s_q.analog_pin_select_reg;
		s_d.p8_out = s_q.group8_data_reg;
		s_d.p8_ana = s_q.analog_pin_select_reg;
		s_d.p12_oe_n = s_q.group12_direction_reg;
		s_d.p12_out = s_q.group12_data_reg;
		s_d.p12_pu = s_q.group12_pullup_reg & s_q.group12_direction_reg;
		s_d.p13_oe_n = s_q.group13_direction_reg;
		s_d.p13_out = s_q.group13_data_reg;
		s_d.p13_pu = s_q.group13_pullup_reg & s_q.group13_direction_reg;
		// readies from the next state: same timing except low in the first cycle after reset; each comes from a flop
		s_d.awready = !s_d.aw_held && !s_d.bvalid;
		s_d.wready = !s_d.w_held && !s_d.bvalid;
		s_d.arready = !s_d.rvalid;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.group8_direction_reg <= group8_direction_rst;
			s_q.group8_data_reg <= group8_data_rst;
			s_q.group12_direction_reg <= group12_direction_rst;
			s_q.group12_data_reg <= group12_data_rst;
			s_q.group12_pullup_reg <= group12_pullup_rst;
			s_q.group13_direction_reg <= group13_direction_rst;
			s_q.group13_data_reg <= group13_data_rst;
			s_q.group13_pullup_reg <= group13_pullup_rst;
			s_q.analog_pin_select_reg <= analog_pin_select_rst;
			s_q.p8_oe_n <= group8_direction_rst;
			s_q.p12_oe_n <= group12_direction_rst;
			s_q.p13_oe_n <= group13_direction_rst;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign analog_shared_pins_out = s_q.p8_out;
	assign analog_shared_pins_oe_n = s_q.p8_oe_n;
	assign analog_input_channels_en = s_q.p8_ana;
	assign osc_group_pins_out = s_q.p12_out;
	assign osc_group_pins_oe_n = s_q.p12_oe_n;
	assign osc_group_pullup_en = s_q.p12_pu;
	assign third_group_pins_out = s_q.p13_out;
	assign third_group_pins_oe_n = s_q.p13_oe_n;
	assign third_group_pullup_en = s_q.p13_pu;
endmodule : upper_port_io

// [verification/pad_model.sv]
/* pad_model: package pins and board lines for one port group.
 assumes: the board always drives a level; oe_n low means the block drives. */
`timescale 1ns/100ps
module pad_model #(
	parameter int w = 8
) (
	input wire logic [w-1:0] out,
	input wire logic [w-1:0] oe_n,
	input wire logic [w-1:0] pu,
	input wire logic [w-1:0] board,
	output logic [w-1:0] pin
);
	// the enabled pull-up beats the board line so that a wrong enable shows on the pin
	always_comb begin
		for (int i = 0; i < w; i++) begin
			pin[i] = !oe_n[i] ? out[i] : (pu[i] ? 1'b1 : board[i]);
		end
	end
endmodule : pad_model

// [verification/upper_port_io_sva.sv]
/* upper_port_io_sva: bus handshake and pad rules of the port block.
 assumes: bound to upper_port_io; one clock, reset sync active low. */
`timescale 1ns/100ps
module upper_port_io_sva
	import upper_port_pkg::*;
(
	input logic aclk,
	input logic aresetn,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic s_axi_bvalid,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic s_axi_rvalid,
	input logic [7:0] analog_shared_pins_oe_n,
	input logic [7:0] analog_input_channels_en,
	input logic [4:0] osc_group_pins_oe_n,
	input logic [4:0] osc_group_pullup_en,
	input logic [2:0] third_group_pins_oe_n,
	input logic [2:0] third_group_pullup_en
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_wr_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	chk_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read not answered");
	chk_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	chk_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	chk_reset_input: assert property (!$past(aresetn) |->
		analog_shared_pins_oe_n == group8_direction_rst
		&& osc_group_pins_oe_n == group12_direction_rst
		&& third_group_pins_oe_n == group13_direction_rst)
		else $error("pins not input after reset");
	chk_output_only: assert property (third_group_pins_oe_n[0] == 1'b0)
		else $error("output-only pin released");
	chk_osc_pullup: assert property (osc_group_pullup_en[4:1] == 4'h0)
		else $error("pull-up on bit without option");
	chk_pullup_input: assert property ((osc_group_pullup_en & ~osc_group_pins_oe_n) == 5'h0
		&& (third_group_pullup_en & ~third_group_pins_oe_n) == 3'h0 && !third_group_pullup_en[0])
		else $error("pull-up on driving pin");
	chk_analog_off: assert property (
		(analog_input_channels_en & ~analog_shared_pins_oe_n) == 8'h0)
		else $error("analog pin driven");
endmodule : upper_port_io_sva
bind upper_port_io upper_port_io_sva sva_i (.*);

// [verification/upper_port_io_tb.sv]
/* upper_port_io_tb: random register setups checked at registers and pads.
 assumes: pad_model stands for the pins; checker bound separately. */
`timescale 1ns/100ps
module upper_port_io_tb
	import upper_port_pkg::*;
;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, board8, analog_shared_pins_in, analog_shared_pins_out;
	logic [7:0] analog_shared_pins_oe_n, analog_input_channels_en;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [4:0] osc_group_pins_in, osc_group_pins_out, osc_group_pins_oe_n, osc_group_pullup_en, board12;
	logic [2:0] third_group_pins_in, third_group_pins_out, third_group_pins_oe_n, board13;
	logic [2:0] third_group_pullup_en;
	logic [31:0] m [9];
	int fail_count, checks, cyc;
	upper_port_io DUT (.*);
	pad_model #(.w(8)) pads8 (.out(analog_shared_pins_out), .oe_n(analog_shared_pins_oe_n),
		.pu(8'h00), .board(board8), .pin(analog_shared_pins_in));
	pad_model #(.w(5)) pads12 (.out(osc_group_pins_out), .oe_n(osc_group_pins_oe_n),
		.pu(osc_group_pullup_en), .board(board12), .pin(osc_group_pins_in));
	pad_model #(.w(3)) pads13 (.out(third_group_pins_out), .oe_n(third_group_pins_oe_n),
		.pu(third_group_pullup_en), .board(board13), .pin(third_group_pins_in));
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// ****************************************
	// expectations and checks
	// ****************************************
	function automatic logic [31:0] msk(input int i);
		case (i)
			2, 3: msk = 32'h1f;
			4: msk = 32'(group12_pullup_mask);
			5: msk = 32'(group13_direction_mask);
			6: msk = 32'h7;
			7: msk = 32'(group13_pullup_mask);
			default: msk = 32'hff;
		endcase
	endfunction : msk
	function automatic logic [31:0] rstv(input int i);
		case (i)
			0: rstv = 32'(group8_direction_rst);
			2: rstv = 32'(group12_direction_rst);
			5: rstv = 32'(group13_direction_rst);
			default: rstv = 32'h0;
		endcase
	endfunction : rstv
	task automatic cmpv(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t value %h expected %h", $time, got, exp);
		end
	endtask : cmpv
	task automatic cmpr(input logic [1:0] got, input logic [1:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t response %h expected %h", $time, got, exp);
		end
	endtask : cmpr
	// ****************************************
	// bus master
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge aclk);
			if (!ta && s_axi_awready) begin
				ta = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!tw && s_axi_wready) begin
				tw = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic reset_check;
		for (int i = 0; i < 9; i++) begin
			rd(8'(i * 4), d, r);
			cmpv(d, rstv(i));
			cmpr(r, resp_okay);
		end
		#1;
		cmpv({16'h0, osc_group_pins_oe_n, third_group_pins_oe_n, analog_shared_pins_oe_n},
			{16'h0, group12_direction_rst, group13_direction_rst, group8_direction_rst});
		$display("test reset done");
	endtask : reset_check
	task automatic results;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results
	// a hang is cut off well above the few thousand cycles the run needs
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			results();
		end
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{board8, board12, board13} = 16'h0;
		s_axi_wstrb = 4'hf;
		fail_count = 0;
		checks = 0;
		void'($urandom(82));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		reset_check();
		// all ones and all zeros first, then random setups
		for (int t = 0; t < 24; t++) begin
			for (int i = 0; i < 9; i++) begin
				d = (t == 0) ? 32'hffffffff : (t == 1) ? 32'h0 : $urandom;
				wr(8'(i * 4), d, r);
				cmpr(r, resp_okay);
				m[i] = d & msk(i);
			end
			for (int i = 0; i < 9; i++) begin
				rd(8'(i * 4), d, r);
				cmpv(d, m[i]);
			end
			board8 <= 8'($urandom);
			board12 <= 5'($urandom);
			board13 <= 3'($urandom);
			repeat (4) @(posedge aclk);
			#1;
			cmpv({8'h0, analog_shared_pins_oe_n, analog_shared_pins_out, analog_input_channels_en},
				{8'h0, m[0][7:0] | m[8][7:0], m[1][7:0], m[8][7:0]});
			cmpv({8'h0, osc_group_pins_oe_n, osc_group_pins_out, osc_group_pullup_en, third_group_pins_oe_n,
				third_group_pins_out, third_group_pullup_en}, {8'h0, m[2][4:0], m[3][4:0],
				m[4][4:0] & m[2][4:0], m[5][2:0], m[6][2:0], m[7][2:0] & m[5][2:0]});
			rd(group8_pin_off, d, r);
			cmpv(d, 32'(~m[8][7:0] & (m[0][7:0] & board8 | ~m[0][7:0] & m[1][7:0])));
			rd(group12_pin_off, d, r);
			cmpv(d, 32'(m[2][4:0] & (m[4][4:0] | board12) | ~m[2][4:0] & m[3][4:0]));
			rd(group13_pin_off, d, r);
			cmpv(d, 32'(m[5][2:0] & (m[7][2:0] | board13) | ~m[5][2:0] & m[6][2:0]));
		end
		$display("test random setup done");
		// low lane strobe off: the register keeps its value
		s_axi_wstrb <= 4'he;
		wr(group8_data_off, ~m[1], r);
		s_axi_wstrb <= 4'hf;
		cmpr(r, resp_okay);
		rd(group8_data_off, d, r);
		cmpv(d, m[1]);
		$display("test strobe done");
		// reset in mid-run with a non-default setup, no transfer under way
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		reset_check();
		wr(8'h30, 32'hffffffff, r);
		cmpr(r, resp_slverr);
		wr(group8_pin_off, 32'hffffffff, r);
		cmpr(r, resp_okay);
		rd(8'hfc, d, r);
		cmpv(d, 32'h0);
		cmpr(r, resp_slverr);
		$display("test unmapped done");
		results();
	end
endmodule : upper_port_io_tb
